// ==== hw/uart_test_gpio_pkg.sv ====
/*
 * Shared constants and carrier types of the UART test and pin block.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package uart_test_gpio_pkg;

	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [31:0] PORT_DATA_FULL_IDX = 32'h1000908e;
	localparam logic [9:0] LINE_CONTROL_IDX = 10'h080;
	localparam logic [9:0] TEST_CONTROL_IDX = 10'h088;
	localparam logic [9:0] FUNC_SELECT_IDX = 10'h08a;
	localparam logic [9:0] DIRECTION_IDX = 10'h08c;
	localparam logic [9:0] PORT_DATA_IDX = PORT_DATA_FULL_IDX[9:0];

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int TEST_FORCE_PARITY_BIT = 2;
	localparam int TEST_LOOPBACK_BIT = 1;
	localparam int TEST_IR_LOOPBACK_BIT = 0;
	localparam int LINE_PARITY_ENABLE_BIT = 0;
	localparam int LINE_IR_MODE_BIT = 1;

	// ---------------------------------------------------------------
	// Pin order and reset values
	// ---------------------------------------------------------------
	localparam int PIN_RXD = 0;
	localparam int PIN_TXD = 1;
	localparam int PIN_RTS = 2;
	localparam int PIN_CTS = 3;
	localparam int PIN_COUNT = 4;
	localparam logic [3:0] FUNC_SELECT_RESET = 4'h0;
	localparam logic [3:0] DIRECTION_RESET = 4'h0;
	localparam logic [3:0] PORT_DATA_RESET = 4'h0;

	typedef struct packed {
		logic force_parity_fault;
		logic loopback;
		logic infrared_loopback;
	} test_ctl_t;

	typedef struct packed {
		logic infrared_mode_enable;
		logic parity_enable;
	} line_ctl_t;

	localparam test_ctl_t TEST_CTL_RESET = 3'h0;
	localparam line_ctl_t LINE_CTL_RESET = 2'h0;

endpackage

// ==== hw/pin_cell.sv ====
/*
 * One shared UART pin: picks between the UART function and general I/O.
 * Assumes the pad combines output and enable into the real wire.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_cell (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic uart_mode,
	input wire logic gpio_dir_out,
	input wire logic gpio_data,
	input wire logic uart_out,
	input wire logic uart_oe,
	output logic pin_out,
	output logic pin_oe
);

	// ---------------------------------------------------------------
	// Output and enable flops
	// ---------------------------------------------------------------
	// direction in UART mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_oe <= 1'b0;
		end else if (ce) begin
			pin_oe <= uart_mode ? uart_oe : gpio_dir_out;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= 1'b0;
		end else if (ce) begin
			pin_out <= uart_mode ? uart_out : gpio_data;
		end
	end

endmodule

`default_nettype wire

// ==== hw/uart_test_gpio.sv ====
/*
 * UART test features (forced parity fault, serial and infrared loopback)
 * and a four-pin general I/O overlay, with an APB register slave.
 * Assumes the UART core supplies its pin outputs, parity bit and infrared
 * transmit stream, and that all pin inputs are synchronous to pclk.
 */
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module uart_test_gpio #(
	parameter int PIN_NUM = 4,
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PIN_NUM-1:0] pin_in,
	output logic [PIN_NUM-1:0] pin_out,
	output logic [PIN_NUM-1:0] pin_oe,
	input wire logic [PIN_NUM-1:0] uart_pin_out,
	input wire logic [PIN_NUM-1:0] uart_pin_oe,
	output logic [PIN_NUM-1:0] uart_pin_level,
	input wire logic tx_parity_raw,
	output logic tx_parity_bit,
	output logic tx_parity_gen_en,
	output logic rx_parity_check_en,
	output logic rx_vote_in,
	input wire logic ir_tx_stream,
	input wire logic ir_rx_pin,
	output logic ir_rx_stream,
	output logic infrared_mode_enable
);

	// ---------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------
	if (PIN_NUM != uart_test_gpio_pkg::PIN_COUNT) begin : g_bad_pins
		$error("PIN_NUM must be 4");
	end
	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 12 and 32");
	end

	// ---------------------------------------------------------------
	// Register decode
	// ---------------------------------------------------------------
	typedef enum {
		SEL_NONE,
		SEL_LINE,
		SEL_TEST,
		SEL_FUNC,
		SEL_DIR,
		SEL_DATA
	} reg_sel_t;

	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		reg_sel_t s;
		s = SEL_NONE;
		if (a[1:0] == 2'h0) begin
			case (a[11:2])
				uart_test_gpio_pkg::LINE_CONTROL_IDX: s = SEL_LINE;
				uart_test_gpio_pkg::TEST_CONTROL_IDX: s = SEL_TEST;
				uart_test_gpio_pkg::FUNC_SELECT_IDX: s = SEL_FUNC;
				uart_test_gpio_pkg::DIRECTION_IDX: s = SEL_DIR;
				uart_test_gpio_pkg::PORT_DATA_IDX: s = SEL_DATA;
				default: s = SEL_NONE;
			endcase
		end
		return s;
	endfunction

	reg_sel_t sel;
	logic access;
	logic wr_en;
	logic [3:0] port_read;
	logic [31:0] rd_mux;

	uart_test_gpio_pkg::test_ctl_t test_r;
	uart_test_gpio_pkg::line_ctl_t line_r;
	logic [3:0] func_sel_r;
	logic [3:0] dir_r;
	logic [3:0] data_r;

	assign sel = decode(paddr);
	assign access = psel && penable && !pready;
	assign wr_en = ce && psel && penable && pready && pwrite;

	// ---------------------------------------------------------------
	// APB handshake: one wait state, answer from flops
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else if (ce) begin
			pready <= access;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (ce) begin
			pslverr <= access && (sel == SEL_NONE);
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// general input reads pin
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			port_read[i] = (!func_sel_r[i] && !dir_r[i]) ? pin_in[i]
				: data_r[i];
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (sel)
			SEL_LINE: rd_mux[1:0] = line_r;
			SEL_TEST: begin
				rd_mux[uart_test_gpio_pkg::TEST_FORCE_PARITY_BIT] =
					test_r.force_parity_fault;
				rd_mux[uart_test_gpio_pkg::TEST_LOOPBACK_BIT] =
					test_r.loopback;
				rd_mux[uart_test_gpio_pkg::TEST_IR_LOOPBACK_BIT] =
					test_r.infrared_loopback;
			end
			SEL_FUNC: rd_mux[3:0] = func_sel_r;
			SEL_DIR: rd_mux[3:0] = dir_r;
			SEL_DATA: rd_mux[3:0] = port_read;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			prdata <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_r <= uart_test_gpio_pkg::LINE_CTL_RESET;
		end else if (wr_en && sel == SEL_LINE) begin
			line_r.parity_enable <=
				pwdata[uart_test_gpio_pkg::LINE_PARITY_ENABLE_BIT];
			line_r.infrared_mode_enable <=
				pwdata[uart_test_gpio_pkg::LINE_IR_MODE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_r <= uart_test_gpio_pkg::TEST_CTL_RESET;
		end else if (wr_en && sel == SEL_TEST) begin
			test_r.force_parity_fault <=
				pwdata[uart_test_gpio_pkg::TEST_FORCE_PARITY_BIT];
			test_r.loopback <= pwdata[uart_test_gpio_pkg::TEST_LOOPBACK_BIT];
			test_r.infrared_loopback <=
				pwdata[uart_test_gpio_pkg::TEST_IR_LOOPBACK_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_sel_r <= uart_test_gpio_pkg::FUNC_SELECT_RESET;
		end else if (wr_en && sel == SEL_FUNC) begin
			func_sel_r <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_r <= uart_test_gpio_pkg::DIRECTION_RESET;
		end else if (wr_en && sel == SEL_DIR) begin
			dir_r <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_r <= uart_test_gpio_pkg::PORT_DATA_RESET;
		end else if (wr_en && sel == SEL_DATA) begin
			data_r <= pwdata[3:0];
		end
	end

	// ---------------------------------------------------------------
	// Pins
	// ---------------------------------------------------------------
	// pin order fixed
	for (genvar i = 0; i < PIN_NUM; i++) begin : g_pin
		pin_cell u_cell (
			.pclk(pclk),
			.presetn(presetn),
			.ce(ce),
			.uart_mode(func_sel_r[i]),
			.gpio_dir_out(dir_r[i]),
			.gpio_data(data_r[i]),
			.uart_out(uart_pin_out[i]),
			.uart_oe(uart_pin_oe[i]),
			.pin_out(pin_out[i]),
			.pin_oe(pin_oe[i])
		);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uart_pin_level <= 4'hf;
		end else if (ce) begin
			uart_pin_level <= pin_in;
		end
	end

	// ---------------------------------------------------------------
	// Test features
	// ---------------------------------------------------------------
	// loopback to voter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_vote_in <= 1'b1;
		end else if (ce) begin
			rx_vote_in <= test_r.loopback
				? pin_out[uart_test_gpio_pkg::PIN_TXD]
				: pin_in[uart_test_gpio_pkg::PIN_RXD];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ir_rx_stream <= 1'b0;
		end else if (ce) begin
			ir_rx_stream <= test_r.infrared_loopback ? ir_tx_stream
				: ir_rx_pin;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_parity_bit <= 1'b0;
		end else if (ce) begin
			tx_parity_bit <= line_r.parity_enable
				&& (tx_parity_raw ^ test_r.force_parity_fault);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_parity_gen_en <= 1'b0;
			rx_parity_check_en <= 1'b0;
			infrared_mode_enable <= 1'b0;
		end else if (ce) begin
			tx_parity_gen_en <= line_r.parity_enable;
			rx_parity_check_en <= line_r.parity_enable;
			infrared_mode_enable <= line_r.infrared_mode_enable;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_TEST_ZERO: assert property (
		@(posedge pclk) disable iff (!presetn)
		(ce && access && !pwrite && sel == SEL_TEST)
			|=> prdata[31:3] == 29'h0)
		else $error("test register upper bits read nonzero");

	AST_PARITY_FORCE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(ce && line_r.parity_enable && test_r.force_parity_fault)
			|=> tx_parity_bit == !$past(tx_parity_raw))
		else $error("forced parity was not inverted");

	AST_LOOP_SRC: assert property (
		@(posedge pclk) disable iff (!presetn)
		(ce && test_r.loopback) |=> rx_vote_in == $past(pin_out[1]))
		else $error("loopback did not feed voter from transmit pin");

	// The reset level is sampled too, so the release edge starts no attempt.
	AST_NO_LOOP: assert property (
		@(posedge pclk) disable iff (!presetn)
		(presetn && ce && !test_r.loopback)
			|=> rx_vote_in == $past(pin_in[0]))
		else $error("voter not fed from receive pin");

	AST_IR_LOOP: assert property (
		@(posedge pclk) disable iff (!presetn)
		(ce && test_r.infrared_loopback)
			|=> ir_rx_stream == $past(ir_tx_stream))
		else $error("infrared loop not closed");

	AST_GPIO_OUT: assert property (
		@(posedge pclk) disable iff (!presetn)
		(ce && !func_sel_r[2] && dir_r[2]) |=> (pin_oe[2] && pin_out[2] ==
			$past(data_r[2])))
		else $error("general output did not drive written data");

	AST_UART_DIR: assert property (
		@(posedge pclk) disable iff (!presetn)
		(ce && func_sel_r[3]) |=> pin_oe[3] == $past(uart_pin_oe[3]))
		else $error("UART mode pin direction not from UART");

	AST_GPIO_READ: assert property (
		@(posedge pclk) disable iff (!presetn)
		(ce && access && !pwrite && sel == SEL_DATA && !func_sel_r[0]
			&& !dir_r[0]) |=> prdata[0] == $past(pin_in[0]))
		else $error("port data read missed pin level");

	AST_PIN_ZERO: assert property (
		@(posedge pclk) disable iff (!presetn)
		(ce && access && !pwrite && sel == SEL_FUNC)
			|=> prdata[31:4] == 28'h0)
		else $error("function select upper bits read nonzero");

	AST_PARITY_OFF: assert property (
		@(posedge pclk) disable iff (!presetn)
		(ce && !line_r.parity_enable)
			|=> !tx_parity_bit && !rx_parity_check_en)
		else $error("parity active while disabled");

endmodule

`default_nettype wire

// ==== dv/tb_uart_test_gpio.sv ====
/*
 * Self-checking bench for the UART test and pin block: APB master,
 * register model and pin model, compared at every result.
 * Assumes the design package and a 12-bit byte address bus.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
	end end

module tb_uart_test_gpio;
	localparam logic [11:0] A_LINE = {uart_test_gpio_pkg::LINE_CONTROL_IDX, 2'b00};
	localparam logic [11:0] A_TEST = {uart_test_gpio_pkg::TEST_CONTROL_IDX, 2'b00};
	localparam logic [11:0] A_FS = {uart_test_gpio_pkg::FUNC_SELECT_IDX, 2'b00};
	localparam logic [11:0] A_DIR = {uart_test_gpio_pkg::DIRECTION_IDX, 2'b00};
	localparam logic [11:0] A_DATA = {uart_test_gpio_pkg::PORT_DATA_IDX, 2'b00};
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, seed = 32'h995c512a;
	logic pready, pslverr, tx_parity_raw = 0, tx_parity_bit;
	logic [3:0] pin_in = '0, pin_out, pin_oe, uart_pin_level;
	logic [3:0] uart_pin_out = '0, uart_pin_oe = '0;
	logic tx_parity_gen_en, rx_parity_check_en, rx_vote_in;
	logic ir_tx_stream = 0, ir_rx_pin = 0, ir_rx_stream, infrared_mode_enable;
	logic [31:0] m_line, m_test, m_fs, m_dir, m_data;
	logic [11:0] addrs[$];
	int mismatches = 0, n_compared = 0, cyc = 0;

	uart_test_gpio dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .uart_pin_out(uart_pin_out),
		.uart_pin_oe(uart_pin_oe), .uart_pin_level(uart_pin_level),
		.tx_parity_raw(tx_parity_raw), .tx_parity_bit(tx_parity_bit),
		.tx_parity_gen_en(tx_parity_gen_en),
		.rx_parity_check_en(rx_parity_check_en), .rx_vote_in(rx_vote_in),
		.ir_tx_stream(ir_tx_stream), .ir_rx_pin(ir_rx_pin),
		.ir_rx_stream(ir_rx_stream),
		.infrared_mode_enable(infrared_mode_enable));

	always #50 pclk = ~pclk;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] exp_rd(logic [11:0] a);
		logic [31:0] v;
		v = '0;
		case (a)
			A_LINE: v = m_line & 32'h3;
			A_TEST: v = m_test & 32'h7;
			A_FS: v = m_fs & 32'hf;
			A_DIR: v = m_dir & 32'hf;
			A_DATA: for (int b = 0; b < 4; b++) begin
				v[b] = (!m_fs[b] && !m_dir[b]) ? pin_in[b] : m_data[b];
			end
			default: v = '0;
		endcase
		return v;
	endfunction

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			complete_run();
		end
	end

	// ---------------------------------------------------------------
	// APB master and model updates
	// ---------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		int n;
		logic ok;
		n = 0;
		ok = a inside {A_LINE, A_TEST, A_FS, A_DIR, A_DATA};
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		`CHK("pready", 1'b1, pready)
		`CHK("pslverr", !ok, pslverr)
		if (!wr) `CHK("prdata", exp_rd(a), prdata)
		psel <= 0;
		penable <= 0;
		if (wr && a == A_LINE) m_line = wd & 32'h3;
		if (wr && a == A_TEST) m_test = wd & 32'h7;
		if (wr && a == A_FS) m_fs = wd & 32'hf;
		if (wr && a == A_DIR) m_dir = wd & 32'hf;
		if (wr && a == A_DATA) m_data = wd & 32'hf;
	endtask

	task automatic rand_in();
		logic [31:0] r;
		r = rnd();
		{pin_in, uart_pin_out, uart_pin_oe} <= r[11:0];
		tx_parity_raw <= r[12];
		ir_tx_stream <= r[13];
		ir_rx_pin <= r[14];
	endtask

	task automatic pins_chk();
		logic [3:0] eoe, eout;
		logic ep, ev;
		repeat (3) @(posedge pclk);
		for (int b = 0; b < 4; b++) begin
			eoe[b] = m_fs[b] ? uart_pin_oe[b] : m_dir[b];
			eout[b] = m_fs[b] ? uart_pin_out[b] : m_data[b];
		end
		`CHK("pin_oe", eoe, pin_oe)
		`CHK("pin_out", eout & eoe, pin_out & eoe)
		`CHK("uart_pin_level", pin_in, uart_pin_level)
		ev = m_test[1] ? eout[1] : pin_in[0];
		ep = m_line[0] & (tx_parity_raw ^ m_test[2]);
		if (!m_test[1] || eoe[1])
			`CHK("rx_vote_in", ev, rx_vote_in)
		`CHK("tx_parity_bit", ep, tx_parity_bit)
		`CHK("gen_en", m_line[0], tx_parity_gen_en)
		`CHK("check_en", m_line[0], rx_parity_check_en)
		`CHK("ir_rx", m_test[0] ? ir_tx_stream : ir_rx_pin, ir_rx_stream)
		`CHK("ir_mode", m_line[1], infrared_mode_enable)
	endtask

	task automatic do_reset();
		{m_line, m_test, m_fs, m_dir, m_data} = '0;
		presetn <= 0;
		repeat (8) @(posedge pclk);
		presetn <= 1;
		`CHK("rst_level", 4'hf, uart_pin_level)
		`CHK("rst_vote", 1'b1, rx_vote_in)
		`CHK("rst_oe", 4'h0, pin_oe)
		foreach (addrs[i]) apb(0, addrs[i], '0);
		pins_chk();
		$display("test reset_values done");
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [11:0] a;
		logic [31:0] d;
		logic [3:0] lvl;
		addrs = '{A_LINE, A_TEST, A_FS, A_DIR, A_DATA, 12'h204, 12'h222};
		do_reset();
		repeat (80) begin
			a = addrs[rnd() % 7];
			d = rnd();
			if (a == A_TEST && m_line[1]) d[1] = 1'b0;
			if (a == A_LINE && m_test[1]) d[1] = 1'b0;
			apb(rnd() % 2, a, d);
			rand_in();
			pins_chk();
		end
		$display("test random_access done");
		// Clock enable low freezes the pin level copy.
		lvl = pin_in;
		ce <= 1'b0;
		pin_in <= ~pin_in;
		repeat (3) @(posedge pclk);
		`CHK("frozen_level", lvl, uart_pin_level)
		ce <= 1'b1;
		pins_chk();
		$display("test clock_enable done");
		// Absent modem pins set as outputs give a defined read.
		apb(1, A_FS, 32'h0);
		apb(1, A_DIR, 32'hc);
		apb(1, A_DATA, 32'ha);
		apb(0, A_DATA, '0);
		$display("test absent_pins done");
		// every test mode, loop kept off in infrared mode.
		apb(1, A_FS, 32'hffff_ffff);
		for (int i = 0; i < 16; i++) begin
			apb(1, A_TEST, 32'h0);
			d = rnd();
			apb(1, A_LINE, {30'h0, !i[1] & d[0], i[3]});
			apb(1, A_TEST, {29'h1fff_ffff, i[2:0]});
			rand_in();
			pins_chk();
			apb(0, A_TEST, '0);
		end
		$display("test test_modes done");
		do_reset();
		complete_run();
	end
endmodule

`default_nettype wire
